// File: core/cse_exec.sv
// How it works
// - Equal-compare with an immediate skips the next instruction when acc equals it.
// - Equal-compare with a memory byte skips the next instruction when acc equals it.
// - Unequal-compare with a memory byte skips the next instruction when they differ.
// - Unequal-compare with an immediate skips the next instruction when they differ.
// - Every compare sets zero, carry, auxiliary carry and overflow as for acc minus operand.
// - Clear-test on an IO bit skips when that bit is low and keeps all flags.
// - Set-test on an IO bit skips when that bit is high and keeps all flags.
// - Clear-test on a memory bit skips when that bit is zero and keeps all flags.
// - Set-test on a memory bit skips when that bit is one and keeps all flags.
// - Increment of acc writes back, sets all four flags and skips on a zero result.
// - Decrement of acc writes back, sets all four flags and skips on a zero result.
// - Increment of memory stores back, sets all four flags and skips on a zero result.
// - Decrement of memory stores back, sets all four flags and skips on a zero result.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cse_cfg.svh"

module cse_exec (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire cse_pkg::cse_op_t op_code,
    input wire logic [7:0] op_imm,
    input wire logic [7:0] op_addr,
    input wire logic [2:0] op_bit,
    output logic op_ready,
    output logic op_done,
    output logic op_skipped,
    output logic [7:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic [7:0] io_addr,
    output logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] acc,
    output logic [3:0] flags
);

    // Operand comes from data memory
    function automatic logic uses_mem(input cse_pkg::cse_op_t op);
        case (op)
            cse_pkg::CSE_OP_CEQ_MEM,
            cse_pkg::CSE_OP_CNE_MEM,
            cse_pkg::CSE_OP_CLR_MEM,
            cse_pkg::CSE_OP_SET_MEM,
            cse_pkg::CSE_OP_INC_MEM,
            cse_pkg::CSE_OP_DEC_MEM: begin
                uses_mem = 1'b1;
            end
            default: begin
                uses_mem = 1'b0;
            end
        endcase
    endfunction

    // Operand comes from an IO port
    function automatic logic uses_io(input cse_pkg::cse_op_t op);
        case (op)
            cse_pkg::CSE_OP_CLR_IO,
            cse_pkg::CSE_OP_SET_IO: begin
                uses_io = 1'b1;
            end
            default: begin
                uses_io = 1'b0;
            end
        endcase
    endfunction

    cse_pkg::cse_state_t state;
    cse_pkg::cse_state_t next_state;
    cse_pkg::cse_op_t cur_op;
    logic [7:0] cur_imm;
    logic [2:0] cur_bit;
    logic skip_pending;
    logic [3:0] last_op;

    cse_alu_if alu_bus ();

    cse_alu u_alu (
        .bus(alu_bus.alu)
    );

    // Request decode
    wire accept = op_ready & op_valid;
    wire drop_now = accept & skip_pending;
    wire run_now = accept & ~skip_pending;
    wire in_group = (op_code != cse_pkg::CSE_OP_OTHER);
    wire in_mem = uses_mem(op_code);
    wire in_io = uses_io(op_code);
    wire start_read = run_now & (in_mem | in_io);
    wire start_exec = run_now & in_group & ~in_mem & ~in_io;
    wire pass_other = run_now & ~in_group;
    wire in_exec = (state == cse_pkg::CSE_ST_EXEC);

    // Current operation decode
    wire cur_mem = uses_mem(cur_op);
    wire cur_io = uses_io(cur_op);
    wire op_ceq_imm = (cur_op == cse_pkg::CSE_OP_CEQ_IMM);
    wire op_ceq_mem = (cur_op == cse_pkg::CSE_OP_CEQ_MEM);
    wire op_cne_mem = (cur_op == cse_pkg::CSE_OP_CNE_MEM);
    wire op_cne_imm = (cur_op == cse_pkg::CSE_OP_CNE_IMM);
    wire op_clr_io = (cur_op == cse_pkg::CSE_OP_CLR_IO);
    wire op_set_io = (cur_op == cse_pkg::CSE_OP_SET_IO);
    wire op_clr_mem = (cur_op == cse_pkg::CSE_OP_CLR_MEM);
    wire op_set_mem = (cur_op == cse_pkg::CSE_OP_SET_MEM);
    wire op_inc_a = (cur_op == cse_pkg::CSE_OP_INC_A);
    wire op_dec_a = (cur_op == cse_pkg::CSE_OP_DEC_A);
    wire op_inc_mem = (cur_op == cse_pkg::CSE_OP_INC_MEM);
    wire op_dec_mem = (cur_op == cse_pkg::CSE_OP_DEC_MEM);
    wire op_cmp = op_ceq_imm | op_ceq_mem | op_cne_mem | op_cne_imm;
    wire op_step_a = op_inc_a | op_dec_a;
    wire op_step_mem = op_inc_mem | op_dec_mem;
    wire op_step = op_step_a | op_step_mem;
    wire op_inc = op_inc_a | op_inc_mem;

    // Operand selection
    wire [7:0] operand = cur_io ? io_rdata : (cur_mem ? mem_rdata : cur_imm);
    wire sel_bit = operand[cur_bit];
    wire same = (acc == operand);

    // Subtractor and incrementer share one adder
    assign alu_bus.a = op_step_mem ? operand : acc;
    assign alu_bus.b = op_step ? `CSE_ONE : operand;
    assign alu_bus.sub = ~op_inc;
    wire result_zero = alu_bus.flags[`CSE_FLAG_Z];

    // Skip decision per operation
    wire skip_ceq = (op_ceq_imm | op_ceq_mem) & same;
    wire skip_cne = (op_cne_mem | op_cne_imm) & ~same;
    wire skip_io = (op_clr_io & ~sel_bit) | (op_set_io & sel_bit);
    wire skip_mem = (op_clr_mem & ~sel_bit) | (op_set_mem & sel_bit);
    wire skip_step = op_step & result_zero;
    wire take_skip = skip_ceq | skip_cne | skip_io | skip_mem | skip_step;

    // Write-back decisions
    wire flag_upd = in_exec & (op_cmp | op_step);
    wire acc_upd = in_exec & op_step_a;
    wire mem_upd = in_exec & op_step_mem;

    // Register port decode
    wire wr_acc = reg_wr & (reg_addr == `CSE_REG_ACC);
    wire wr_flags = reg_wr & (reg_addr == `CSE_REG_FLAGS);
    wire busy = ~op_ready;
    wire [7:0] status_word = {last_op, 2'b00, busy, skip_pending};
    wire [7:0] rd_word = (reg_addr == `CSE_REG_ACC) ? acc :
                         (reg_addr == `CSE_REG_FLAGS) ? {4'h0, flags} :
                         (reg_addr == `CSE_REG_STATUS) ? status_word : `CSE_BYTE_RST;

    // Next values
    wire [7:0] next_acc = acc_upd ? alu_bus.res : (wr_acc ? reg_wdata : acc);
    wire [3:0] next_flags = flag_upd ? alu_bus.flags : (wr_flags ? reg_wdata[3:0] : flags);
    wire next_skip = drop_now ? 1'b0 : (in_exec ? take_skip : skip_pending);
    wire next_done = drop_now | pass_other | in_exec;
    wire next_ready = (next_state == cse_pkg::CSE_ST_IDLE);
    wire [7:0] next_rdata = reg_rd ? rd_word : `CSE_BYTE_RST;

    always_comb begin
        next_state = state;
        case (state)
            cse_pkg::CSE_ST_IDLE: begin
                if (start_read) begin
                    next_state = cse_pkg::CSE_ST_READ;
                end else if (start_exec) begin
                    next_state = cse_pkg::CSE_ST_EXEC;
                end
            end
            cse_pkg::CSE_ST_READ: begin
                next_state = cse_pkg::CSE_ST_EXEC;
            end
            cse_pkg::CSE_ST_EXEC: begin
                next_state = cse_pkg::CSE_ST_IDLE;
            end
            default: begin
                next_state = cse_pkg::CSE_ST_IDLE;
            end
        endcase
    end

    // Sequencer and handshake
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= cse_pkg::CSE_ST_IDLE;
            op_ready <= 1'b0;
            op_done <= 1'b0;
            op_skipped <= 1'b0;
            skip_pending <= 1'b0;
        end else begin
            state <= next_state;
            op_ready <= next_ready;
            op_done <= next_done;
            op_skipped <= drop_now;
            skip_pending <= next_skip;
        end
    end

    // Latched instruction fields
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cur_op <= cse_pkg::CSE_OP_OTHER;
            cur_imm <= `CSE_BYTE_RST;
            cur_bit <= 3'h0;
            last_op <= 4'h0;
        end else if (run_now) begin
            cur_op <= op_code;
            cur_imm <= op_imm;
            cur_bit <= op_bit;
            last_op <= op_code;
        end
    end

    // Memory and IO strobes
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mem_addr <= `CSE_BYTE_RST;
            io_addr <= `CSE_BYTE_RST;
            mem_rd <= 1'b0;
            io_rd <= 1'b0;
        end else begin
            mem_rd <= start_read & in_mem;
            io_rd <= start_read & in_io;
            if (start_read & in_mem) begin
                mem_addr <= op_addr;
            end
            if (start_read & in_io) begin
                io_addr <= op_addr;
            end
        end
    end

    // Memory write-back
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mem_wr <= 1'b0;
            mem_wdata <= `CSE_BYTE_RST;
        end else begin
            mem_wr <= mem_upd;
            mem_wdata <= mem_upd ? alu_bus.res : mem_wdata;
        end
    end

    // Accumulator, flags and register read port
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            acc <= `CSE_ACC_RST;
            flags <= `CSE_FLAGS_RST;
            reg_rdata <= `CSE_BYTE_RST;
        end else begin
            acc <= next_acc;
            flags <= next_flags;
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// File: core/cse_cfg.svh
`ifndef CSE_CFG_SVH
`define CSE_CFG_SVH

// Register port offsets
`define CSE_REG_ACC 2'h0
`define CSE_REG_FLAGS 2'h1
`define CSE_REG_STATUS 2'h2

// Flag field positions
`define CSE_FLAG_Z 0
`define CSE_FLAG_C 1
`define CSE_FLAG_AC 2
`define CSE_FLAG_OV 3

// Status field positions
`define CSE_STAT_SKIP 0
`define CSE_STAT_BUSY 1
`define CSE_STAT_LAST_LSB 4

// Reset values
`define CSE_ACC_RST 8'h00
`define CSE_FLAGS_RST 4'h0
`define CSE_BYTE_RST 8'h00

// Step for increment and decrement
`define CSE_ONE 8'h01

`endif

// File: core/cse_pkg.sv
package cse_pkg;

    typedef enum logic [3:0] {
        CSE_OP_OTHER = 4'h0,
        CSE_OP_CEQ_IMM = 4'h1,
        CSE_OP_CEQ_MEM = 4'h2,
        CSE_OP_CNE_MEM = 4'h3,
        CSE_OP_CNE_IMM = 4'h4,
        CSE_OP_CLR_IO = 4'h5,
        CSE_OP_SET_IO = 4'h6,
        CSE_OP_CLR_MEM = 4'h7,
        CSE_OP_SET_MEM = 4'h8,
        CSE_OP_INC_A = 4'h9,
        CSE_OP_DEC_A = 4'ha,
        CSE_OP_INC_MEM = 4'hb,
        CSE_OP_DEC_MEM = 4'hc
    } cse_op_t;

    typedef enum logic [2:0] {
        CSE_ST_IDLE = 3'h1,
        CSE_ST_READ = 3'h2,
        CSE_ST_EXEC = 3'h4
    } cse_state_t;

endpackage

// File: core/cse_alu_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cse_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic sub;
    logic [7:0] res;
    logic [3:0] flags;

    modport core (output a, output b, output sub, input res, input flags);
    modport alu (input a, input b, input sub, output res, output flags);
endinterface

`default_nettype wire

// File: core/cse_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "cse_cfg.svh"

module cse_alu (
    cse_alu_if.alu bus
);

    // Add or subtract with carry or borrow in the top bit
    function automatic logic [8:0] arith(input logic [7:0] x, input logic [7:0] y,
                                         input logic sub);
        arith = sub ? ({1'b0, x} - {1'b0, y}) : ({1'b0, x} + {1'b0, y});
    endfunction

    wire [8:0] full = arith(bus.a, bus.b, bus.sub);
    wire [8:0] low_nib = arith({4'h0, bus.a[3:0]}, {4'h0, bus.b[3:0]}, bus.sub);
    wire sign_a = bus.a[7];
    wire sign_b = bus.b[7];
    wire sign_r = full[7];
    wire ov_add = ~(sign_a ^ sign_b) & (sign_r ^ sign_a);
    wire ov_sub = (sign_a ^ sign_b) & (sign_r ^ sign_a);

    assign bus.res = full[7:0];
    assign bus.flags[`CSE_FLAG_Z] = (full[7:0] == 8'h00);
    assign bus.flags[`CSE_FLAG_C] = full[8];
    assign bus.flags[`CSE_FLAG_AC] = low_nib[4];
    assign bus.flags[`CSE_FLAG_OV] = bus.sub ? ov_sub : ov_add;

endmodule

`default_nettype wire

// File: bench/cse_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module cse_mem_model (
    input wire logic sys_clk,
    input wire logic [7:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic [7:0] io_addr,
    input wire logic io_rd,
    output logic [7:0] io_rdata
);
    logic [7:0] mem [256];
    logic [7:0] io [256];

    initial begin
        mem_rdata = 8'h00;
        io_rdata = 8'h00;
    end

    // Data only in the cycle after a strobe, toggling junk otherwise
    always @(posedge sys_clk) begin
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
        io_rdata <= io_rd ? io[io_addr] : ~io_rdata;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

`default_nettype wire

// File: bench/cse_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cse_exec_monitor (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic op_skipped,
    input wire logic [7:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic io_rd,
    input wire logic [7:0] acc,
    input wire logic [3:0] flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_skip_quiet: assert property (op_skipped |-> op_done && !mem_wr && !mem_rd && !io_rd)
        else $error("skip with bus activity");
    a_skip_keeps: assert property (op_skipped |-> $stable(acc) && $stable(flags))
        else $error("skip changed state");
    a_mem_answer: assert property (mem_rd |=> !op_done ##1 op_done && op_ready)
        else $error("memory op done late");
    a_io_flags: assert property (io_rd |=> $stable(flags) [*2] ##0 op_done)
        else $error("io test touched flags");
    a_wr_after_rd: assert property (mem_wr |-> $past(mem_rd, 2) && op_done
        && mem_addr == $past(mem_addr, 2))
        else $error("write without read");
    a_wr_step: assert property (mem_wr |-> mem_wdata == $past(mem_rdata) + 8'h01
        || mem_wdata == $past(mem_rdata) - 8'h01)
        else $error("write value not one step");
    a_wr_zero: assert property (mem_wr |-> flags[0] == (mem_wdata == 8'h00))
        else $error("zero flag wrong on store");
    a_acc_zero: assert property (op_done && $changed(acc) |-> flags[0] == (acc == 8'h00))
        else $error("zero flag wrong on acc");
endmodule

bind cse_exec cse_exec_monitor cse_exec_monitor_inst (.sys_clk, .resetn, .op_ready, .op_done,
    .op_skipped, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .io_rd, .acc, .flags);

`default_nettype wire

// File: bench/conditional_skip_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

module conditional_skip_exec_tb;
    logic sys_clk, resetn, op_valid, op_ready, op_done, op_skipped, mem_rd, mem_wr, io_rd;
    logic reg_wr, reg_rd, rd_d, pend;
    cse_pkg::cse_op_t op_code;
    logic [7:0] op_imm, op_addr, mem_addr, mem_rdata, mem_wdata, io_addr, io_rdata;
    logic [7:0] reg_wdata, reg_rdata, acc, m_acc;
    logic [2:0] op_bit;
    logic [1:0] reg_addr;
    logic [3:0] flags, m_flags, last;
    logic [21:0] note;
    logic [21:0] oq[$];
    logic [7:0] rq[$];
    logic [7:0] edge_v [8] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff, 8'h0f, 8'h10, 8'hfe};
    integer seed = 13, fails = 0, compares = 0, cyc = 0, i;

    cse_exec cse_exec_inst (.sys_clk, .resetn, .op_valid, .op_code, .op_imm, .op_addr, .op_bit,
        .op_ready, .op_done, .op_skipped, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata,
        .io_addr, .io_rd, .io_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .acc, .flags);
    cse_mem_model cse_mem_model_inst (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
        .mem_rdata, .io_addr, .io_rd, .io_rdata);

    function automatic logic [3:0] fsub(input logic [7:0] a, input logic [7:0] s);
        logic [7:0] d;
        d = a - s;
        return {a[7] != s[7] && d[7] != a[7], a[3:0] < s[3:0], a < s, d == 8'h00};
    endfunction

    function automatic logic [3:0] finc(input logic [7:0] a);
        return {a == 8'h7f, a[3:0] == 4'hf, a == 8'hff, a == 8'hff};
    endfunction

    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic reg_op(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        if (w && a == 2'h0) m_acc = d;
        if (w && a == 2'h1) m_flags = d[3:0];
        if (!w) rq.push_back(a == 2'h0 ? m_acc : a == 2'h1 ? {4'h0, m_flags} :
            a == 2'h2 ? {last, 3'h0, pend} : 8'h00);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic step;
        logic [31:0] x, y;
        logic [7:0] ad, im, mv, iv, o, src, r, nacc;
        logic [3:0] k, nfl;
        logic [2:0] b;
        logic sk, wr;
        @(posedge sys_clk);
        x = $random(seed);
        y = $random(seed);
        case (y[2:0])
            3'h0: reg_op(1'b1, 2'h0, edge_v[y[5:3]]);
            3'h1: reg_op(1'b1, 2'h1, y[15:8]);
            3'h2: reg_op(1'b0, y[13:12], 8'h00);
            3'h3: reg_op(1'b1, y[13:12], y[31:24]);
            default: ;
        endcase
        // Codes 0..12 cover every op and the foreign one
        k = x[30:27] % 4'hd;
        ad = x[23:16];
        b = x[10:8];
        im = x[6] ? m_acc : x[31:24];
        if (x[7]) cse_mem_model_inst.mem[ad] = x[11] ? m_acc : edge_v[x[14:12]];
        mv = cse_mem_model_inst.mem[ad];
        iv = cse_mem_model_inst.io[ad];
        o = (k == 4'h1 || k == 4'h4) ? im : mv;
        src = (k > 4'ha) ? mv : m_acc;
        r = k[0] ? src + 8'h01 : src - 8'h01;
        {nacc, nfl, sk, wr} = {m_acc, m_flags, 2'b00};
        if (!pend) begin
            case (k)
                4'h1, 4'h2, 4'h3, 4'h4: {nfl, sk} = {fsub(m_acc, o), (m_acc == o) ^ (k > 4'h2)};
                4'h5, 4'h6: sk = iv[b] ^ (k == 4'h5);
                4'h7, 4'h8: sk = mv[b] ^ (k == 4'h7);
                4'h9, 4'ha, 4'hb, 4'hc: begin
                    nfl = k[0] ? finc(src) : fsub(src, 8'h01);
                    sk = r == 8'h00;
                    wr = k > 4'ha;
                    nacc = wr ? m_acc : r;
                end
                default: ;
            endcase
        end
        oq.push_back({wr, wr ? r : 8'h00, pend, nfl, nacc});
        if (!pend) last = k;
        {pend, m_acc, m_flags} = {sk, nacc, nfl};
        op_valid <= 1'b1;
        op_code <= cse_pkg::cse_op_t'(k);
        op_imm <= im;
        op_addr <= ad;
        op_bit <= b;
        @(posedge sys_clk);
        while (op_ready !== 1'b1) @(posedge sys_clk);
        op_valid <= 1'b0;
        @(posedge sys_clk);
        while (op_done !== 1'b1) @(posedge sys_clk);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Result watcher and hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            wrap_up();
        end
        if (rd_d) begin
            check({14'h0000, reg_rdata}, {14'h0000, rq.pop_front()});
        end
        rd_d <= reg_rd;
        if (op_done === 1'b1) begin
            note = oq.pop_front();
            check({op_skipped, flags, acc}, note[12:0]);
            check({mem_wr, mem_wr ? mem_wdata : 8'h00}, note[21:13]);
        end
    end

    initial begin
        {op_valid, reg_wr, reg_rd, rd_d, resetn, pend} = '0;
        {op_imm, op_addr, op_bit, reg_addr, reg_wdata, m_acc, m_flags, last} = '0;
        op_code = cse_pkg::CSE_OP_OTHER;
        for (i = 0; i < 256; i++) begin
            cse_mem_model_inst.mem[i] = $random(seed);
            cse_mem_model_inst.io[i] = $random(seed);
        end
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 500; i++) begin
            if (i == 250) begin
                resetn <= 1'b0;
                repeat (2) @(posedge sys_clk);
                check({op_ready, op_done, op_skipped, mem_rd, mem_wr, io_rd}, 22'h0);
                check({flags, acc}, 22'h0);
                resetn <= 1'b1;
                {pend, last, m_acc, m_flags} = '0;
            end
            step();
        end
        repeat (4) @(posedge sys_clk);
        wrap_up();
    end
endmodule

`default_nettype wire
